// File: common/iss_defines.svh
// Functional notes
// - After reset requests stay masked until an unmask instruction or a return with unmask option executes.
// - An enabled request waits until the running instruction completes.
// - Taking a request pushes the address of the preempted instruction.
// - Taking a request saves zero and carry into a shadow store.
// - Taking a request clears the enable flag.
// - Taking a request loads the program counter with all ones.
// - The vector is the last location, whatever the store width.
// - Acknowledge goes high during the interrupt sequence.
// - Return with unmask option returns and sets the enable flag.
// - Return with mask option returns and leaves the enable flag clear.
// - Return from interrupt restores the saved zero and carry flags.
// - Return pops the stack top into the counter without increment.
// - Request is seen when the address changes; that address is pushed.
// - Mask instruction clears enable, unmask instruction sets it.
// - A 64 byte scratchpad moves bytes by store and fetch.
// - Reset leaves scratchpad contents untouched.
// - Direct mode addresses the scratchpad with the instruction constant.
// - Indirect mode addresses the scratchpad with a register's contents.
// - The event lasts two cycles; acknowledge is high in the second.
`ifndef ISS_DEFINES_SVH
`define ISS_DEFINES_SVH
`define ISS_REG_CTRL 8'h00
`define ISS_REG_STATUS 8'h04
`define ISS_REG_SAVED_PC 8'h08
`define ISS_REG_COUNT 8'h0C
`define ISS_CTRL_GATE_BIT 0
`define ISS_CTRL_RESET 1'b1
`define ISS_ST_ENABLE_BIT 0
`define ISS_ST_BUSY_BIT 1
`define ISS_ST_ZERO_BIT 2
`define ISS_ST_CARRY_BIT 3
`define ISS_SPAD_DEPTH 64
`define ISS_SPAD_AW 6
`define ISS_PC_W 10
`define ISS_EVENT_CYCLES 2
`endif

// File: common/iss_pkg.sv
package iss_pkg;
	typedef enum logic [1:0] {
		ISS_IDLE,
		ISS_EV_FIRST,
		ISS_EV_ACK
	} iss_state_type;
endpackage : iss_pkg

// File: logic/iss_scratchpad.sv
`timescale 1ns/1ps
module iss_scratchpad #(
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	// No reset on the array or read register
	logic [7:0] mem [DEPTH];

	generate
		if (DEPTH != (1 << AW)) begin : g_bad_depth
			$error("Scratchpad depth must equal two to the address width");
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end
endmodule : iss_scratchpad

// File: logic/iss_irq_sequencer.sv
`timescale 1ns/1ps
`include "iss_defines.svh"
module iss_irq_sequencer #(
	parameter int PC_W = `ISS_PC_W,
	parameter int SPAD_DEPTH = `ISS_SPAD_DEPTH,
	parameter int SPAD_AW = `ISS_SPAD_AW
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// Interrupt request from fabric
	input wire logic irq_i,
	output logic irq_ack_o,
	// Instruction stream
	input wire logic insn_done_i,
	input wire logic [PC_W-1:0] next_pc_i,
	input wire logic op_irq_unmask_i,
	input wire logic op_irq_mask_i,
	input wire logic return_from_irq_unmasked_i,
	input wire logic return_from_irq_masked_i,
	input wire logic [PC_W-1:0] stack_top_i,
	input wire logic zero_i,
	input wire logic carry_i,
	output logic busy_o,
	output logic stack_push_o,
	output logic stack_pop_o,
	output logic [PC_W-1:0] push_pc_o,
	output logic pc_load_o,
	output logic [PC_W-1:0] pc_value_o,
	output logic flags_restore_o,
	output logic zero_o,
	output logic carry_o,
	output logic irq_enable_o,
	// Scratchpad access
	input wire logic store_i,
	input wire logic fetch_i,
	input wire logic indirect_i,
	input wire logic [7:0] imm_addr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] store_data_i,
	output logic [7:0] fetch_data_o,
	output logic fetch_valid_o,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	generate
		if (PC_W < 4 || PC_W > 16) begin : g_bad_pc
			$error("Program counter width out of range");
		end
		if (SPAD_AW > 8) begin : g_bad_aw
			$error("Scratchpad address wider than a byte");
		end
	endgenerate

	localparam logic [PC_W-1:0] VECTOR = {PC_W{1'b1}};

	function automatic logic [SPAD_AW-1:0] spad_index(input logic ind, input logic [7:0] imm,
			input logic [7:0] rg);
		spad_index = ind ? rg[SPAD_AW-1:0] : imm[SPAD_AW-1:0];
	endfunction : spad_index

	iss_pkg::iss_state_type state;
	logic gate;
	logic saved_zero;
	logic saved_carry;
	logic [PC_W-1:0] saved_pc;
	logic [15:0] take_count;
	logic [7:0] ram_rdata;

	wire idle = (state == iss_pkg::ISS_IDLE);
	wire done = insn_done_i && idle;
	wire any_op = op_irq_unmask_i || op_irq_mask_i || return_from_irq_unmasked_i ||
		return_from_irq_masked_i;
	wire take = done && irq_i && irq_enable_o && gate && !any_op;
	wire do_return = done && (return_from_irq_unmasked_i || return_from_irq_masked_i);
	wire [SPAD_AW-1:0] spad_addr = spad_index(indirect_i, imm_addr_i, reg_addr_i);
	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wb_wr = wb_req && wb_we_i;
	wire hit_ctrl = (wb_adr_i == `ISS_REG_CTRL);
	wire hit_status = (wb_adr_i == `ISS_REG_STATUS);
	wire hit_pc = (wb_adr_i == `ISS_REG_SAVED_PC);
	wire hit_count = (wb_adr_i == `ISS_REG_COUNT);
	wire [31:0] status_word = {28'h000_0000, saved_carry, saved_zero, !idle, irq_enable_o};
	wire [31:0] next_rdata = hit_ctrl ? {31'h0000_0000, gate} :
		hit_status ? status_word :
		hit_pc ? {{(32-PC_W){1'b0}}, saved_pc} :
		hit_count ? {16'h0000, take_count} : 32'h0000_0000;

	iss_scratchpad #(
		.DEPTH(SPAD_DEPTH),
		.AW(SPAD_AW)
	) u_spad (
		.clk_i(clk_i),
		.we_i(store_i),
		.addr_i(spad_addr),
		.wdata_i(store_data_i),
		.rdata_o(ram_rdata)
	);

	// Interrupt event sequencing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= iss_pkg::ISS_IDLE;
			irq_ack_o <= 1'b0;
			busy_o <= 1'b0;
			stack_push_o <= 1'b0;
			push_pc_o <= '0;
		end else begin
			case (state)
				iss_pkg::ISS_IDLE: begin
					if (take) begin
						state <= iss_pkg::ISS_EV_FIRST;
						busy_o <= 1'b1;
						stack_push_o <= 1'b1;
						push_pc_o <= next_pc_i;
					end
				end
				iss_pkg::ISS_EV_FIRST: begin
					state <= iss_pkg::ISS_EV_ACK;
					stack_push_o <= 1'b0;
					irq_ack_o <= 1'b1;
				end
				iss_pkg::ISS_EV_ACK: begin
					state <= iss_pkg::ISS_IDLE;
					irq_ack_o <= 1'b0;
					busy_o <= 1'b0;
				end
				default: begin
					state <= iss_pkg::ISS_IDLE;
				end
			endcase
		end
	end

	// Program counter loads for vector and return
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_load_o <= 1'b0;
			pc_value_o <= '0;
			stack_pop_o <= 1'b0;
		end else begin
			pc_load_o <= take || do_return;
			stack_pop_o <= do_return;
			if (take) begin
				pc_value_o <= VECTOR;
			end else if (do_return) begin
				pc_value_o <= stack_top_i;
			end
		end
	end

	// Enable flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_enable_o <= 1'b0;
		end else if (take) begin
			irq_enable_o <= 1'b0;
		end else if (done && (op_irq_unmask_i || return_from_irq_unmasked_i)) begin
			irq_enable_o <= 1'b1;
		end else if (done && (op_irq_mask_i || return_from_irq_masked_i)) begin
			irq_enable_o <= 1'b0;
		end
	end

	// Shadow flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			saved_zero <= 1'b0;
			saved_carry <= 1'b0;
			saved_pc <= '0;
			flags_restore_o <= 1'b0;
			zero_o <= 1'b0;
			carry_o <= 1'b0;
			take_count <= 16'h0000;
		end else begin
			flags_restore_o <= do_return;
			if (take) begin
				saved_zero <= zero_i;
				saved_carry <= carry_i;
				saved_pc <= next_pc_i;
				take_count <= take_count + 16'h0001;
			end
			if (do_return) begin
				zero_o <= saved_zero;
				carry_o <= saved_carry;
			end
		end
	end

	// Fetch result
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fetch_valid_o <= 1'b0;
		end else begin
			fetch_valid_o <= fetch_i;
		end
	end
	assign fetch_data_o = ram_rdata;

	// Wishbone slave, one wait-state registered ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			gate <= `ISS_CTRL_RESET;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= next_rdata;
			end
			if (wb_wr && hit_ctrl && wb_sel_i[0]) begin
				gate <= wb_dat_i[`ISS_CTRL_GATE_BIT];
			end
		end
	end
endmodule : iss_irq_sequencer

// File: sim/iss_irq_properties.sv
`timescale 1ns/1ps
module iss_irq_properties #(
	parameter int PC_W = 10
) (
	input wire logic clk_i, rst_i, irq_i, irq_ack_o, insn_done_i, busy_o, irq_enable_o,
	input wire logic op_irq_unmask_i, op_irq_mask_i, fetch_i, fetch_valid_o,
	input wire logic return_from_irq_unmasked_i, return_from_irq_masked_i,
	input wire logic stack_push_o, stack_pop_o, pc_load_o, flags_restore_o,
	input wire logic [PC_W-1:0] next_pc_i, stack_top_i, push_pc_o, pc_value_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic go = insn_done_i && !busy_o;
	wire logic any_op = op_irq_unmask_i || op_irq_mask_i || return_from_irq_unmasked_i
		|| return_from_irq_masked_i;
	a_take_push: assert property (go && irq_i && irq_enable_o && !any_op |=>
		stack_push_o && push_pc_o == $past(next_pc_i)) else $error("push missing");
	a_vector_load: assert property (stack_push_o |-> pc_load_o && &pc_value_o)
		else $error("vector wrong");
	a_take_masks: assert property (stack_push_o |-> !irq_enable_o)
		else $error("enable kept");
	a_ack_second: assert property (stack_push_o |=> irq_ack_o && busy_o ##1
		!irq_ack_o && !busy_o) else $error("ack timing");
	a_ack_cause: assert property ($rose(irq_ack_o) |-> $past(stack_push_o))
		else $error("stray ack");
	a_no_take_off: assert property (!irq_enable_o |=> !stack_push_o)
		else $error("take while masked");
	a_ret_unmask: assert property (go && return_from_irq_unmasked_i |=> stack_pop_o
		&& pc_value_o == $past(stack_top_i) && irq_enable_o) else $error("return on");
	a_ret_mask: assert property (go && return_from_irq_masked_i |=> stack_pop_o
		&& flags_restore_o && !irq_enable_o) else $error("return off");
	a_unmask_op: assert property (go && op_irq_unmask_i |=> irq_enable_o)
		else $error("unmask lost");
	a_fetch_valid: assert property (fetch_i |=> fetch_valid_o)
		else $error("fetch late");
endmodule : iss_irq_properties

// File: sim/iss_irq_source.sv
`timescale 1ns/1ps
module iss_irq_source (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic fire_i,
	input wire logic ack_i,
	output logic irq_o
);
	// Request holds until acknowledged, never shorter than two cycles
	always_ff @(posedge clk_i) begin
		if (rst_i || ack_i) begin
			irq_o <= 1'b0;
		end else if (fire_i) begin
			irq_o <= 1'b1;
		end
	end
endmodule : iss_irq_source

// File: sim/tb_iss_irq_sequencer.sv
`timescale 1ns/1ps
module tb_iss_irq_sequencer;
	logic clk_i, rst_i, irq_i, irq_ack_o, insn_done_i, zero_i, carry_i, busy_o, fire;
	logic op_irq_unmask_i, op_irq_mask_i, return_from_irq_unmasked_i, return_from_irq_masked_i;
	logic stack_push_o, stack_pop_o, pc_load_o, flags_restore_o, zero_o, carry_o, irq_enable_o;
	logic store_i, fetch_i, indirect_i, fetch_valid_o, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [9:0] next_pc_i, stack_top_i, push_pc_o, pc_value_o;
	logic [7:0] imm_addr_i, reg_addr_i, store_data_i, fetch_data_o, wb_adr_i;
	logic [3:0] wb_sel_i, ops;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	int err_count, cmp_count, cycles;
	assign {op_irq_unmask_i, op_irq_mask_i, return_from_irq_unmasked_i,
		return_from_irq_masked_i} = ops;
	iss_irq_sequencer i_iss_irq_sequencer (.*);
	iss_irq_source i_iss_irq_source (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
		.ack_i(irq_ack_o), .irq_o(irq_i));
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task close_out();
		$display("cmp_count=%0d err_count=%0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out
	task reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask : reset
	task insn(input logic [3:0] op, input logic [9:0] pc);
		@(posedge clk_i);
		insn_done_i <= 1'b1;
		next_pc_i <= pc;
		stack_top_i <= pc;
		ops <= op;
		@(posedge clk_i);
		insn_done_i <= 1'b0;
		ops <= 4'h0;
		@(negedge clk_i);
	endtask : insn
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		wb_sel_i <= 4'hf;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask : wb
	task sp(input logic st, input logic ind, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		{store_i, fetch_i, indirect_i, store_data_i} <= {st, !st, ind, d};
		imm_addr_i <= ind ? ~a : a;
		reg_addr_i <= ind ? a : ~a;
		@(posedge clk_i);
		{store_i, fetch_i} <= 2'b00;
		@(negedge clk_i);
	endtask : sp
	always @(posedge clk_i) if (++cycles == 3000) begin
		err_count++;
		close_out();
	end
	initial begin
		clk_i = 0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		{rst_i, insn_done_i, ops, fire, store_i, fetch_i, indirect_i} = '0;
		{zero_i, carry_i, next_pc_i, stack_top_i, imm_addr_i, reg_addr_i} = '0;
		{store_data_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		{err_count, cmp_count, cycles, wb_sel_i} = '0;
		reset();
		{fire, zero_i} <= 2'b11;
		insn(4'h0, 10'h010);
		chk(stack_push_o, 1'b0);
		insn(4'h8, 10'h011);
		chk({stack_push_o, irq_enable_o}, 2'b01);
		insn(4'h0, 10'h123);
		chk({busy_o, pc_value_o, push_pc_o, irq_enable_o}, {1'b1, 10'h3ff, 10'h123, 1'b0});
		@(negedge clk_i);
		chk(irq_ack_o, 1'b1);
		@(posedge clk_i);
		{fire, zero_i, carry_i} <= 3'b001;
		insn(4'h1, 10'h123);
		chk({pc_value_o, zero_o, carry_o, irq_enable_o}, {10'h123, 3'b100});
		wb(1'b1, 8'h04, 32'h0000_0000);
		wb(1'b0, 8'h04, 32'h0000_0000);
		chk(q, 32'h0000_0004);
		wb(1'b0, 8'h08, 32'h0000_0000);
		chk(q, 32'h0000_0123);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		wb(1'b1, 8'h00, 32'h0000_0000);
		wb(1'b0, 8'h00, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		wb(1'b1, 8'h00, 32'h0000_0001);
		wb(1'b0, 8'h00, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		insn(4'h8, 10'h124);
		@(posedge clk_i);
		fire <= 1'b1;
		insn(4'h0, 10'h3ff);
		chk({pc_value_o, push_pc_o}, {10'h3ff, 10'h3ff});
		repeat (2) @(posedge clk_i);
		fire <= 1'b0;
		insn(4'h2, 10'h3ff);
		chk({stack_pop_o, irq_enable_o}, 2'b11);
		wb(1'b0, 8'h0c, 32'h0000_0000);
		chk(q, 32'h0000_0002);
		sp(1'b1, 1'b0, 8'hc4, 8'ha5);
		sp(1'b1, 1'b1, 8'h05, 8'h5a);
		sp(1'b0, 1'b1, 8'h44, 8'h00);
		chk({fetch_valid_o, fetch_data_o}, 9'h1a5);
		sp(1'b0, 1'b0, 8'h85, 8'h00);
		chk(fetch_data_o, 8'h5a);
		reset();
		sp(1'b0, 1'b0, 8'h04, 8'h00);
		chk(fetch_data_o, 8'ha5);
		close_out();
	end
endmodule : tb_iss_irq_sequencer
bind iss_irq_sequencer iss_irq_properties #(.PC_W(PC_W)) i_iss_irq_properties (.*);
